// file: logic/gpabc_pkg.sv
// Package of register map, field layout and reset values for the three-port GPIO block
package gpabc_pkg;
   localparam int PORT_COUNT = 3;
   localparam int PORT_WIDTH = 8;
   localparam int SLOTS_PER_PORT = 4;
   localparam int SUBREG_COUNT = 4;
   // Printed offsets are not all multiples of four, so these are word indices
   localparam logic [11:0] PORT_A_SUBREG_SELECT_IDX = 12'hfd0;
   localparam logic [11:0] PORT_A_SUBREG_DATA_IDX = 12'hfd1;
   localparam logic [11:0] PORT_A_INPUT_SAMPLE_IDX = 12'hfd2;
   localparam logic [11:0] PORT_A_OUTPUT_DRIVE_IDX = 12'hfd3;
   localparam logic [11:0] PORT_B_SUBREG_SELECT_IDX = 12'hfd4;
   localparam logic [11:0] PORT_B_SUBREG_DATA_IDX = 12'hfd5;
   localparam logic [11:0] PORT_B_INPUT_SAMPLE_IDX = 12'hfd6;
   localparam logic [11:0] PORT_B_OUTPUT_DRIVE_IDX = 12'hfd7;
   localparam logic [11:0] PORT_C_SUBREG_SELECT_IDX = 12'hfd8;
   localparam logic [11:0] PORT_C_SUBREG_DATA_IDX = 12'hfd9;
   localparam logic [11:0] PORT_C_INPUT_SAMPLE_IDX = 12'hfda;
   localparam logic [11:0] PORT_C_OUTPUT_DRIVE_IDX = 12'hfdb;
   localparam logic [11:0] FIRST_IDX = PORT_A_SUBREG_SELECT_IDX;
   localparam logic [11:0] LAST_IDX = PORT_C_OUTPUT_DRIVE_IDX;
   localparam int ADDR_WIDTH = 14;
   // Slot numbers inside one port's block
   localparam logic [1:0] SLOT_SELECT = 2'h0;
   localparam logic [1:0] SLOT_DATA = 2'h1;
   localparam logic [1:0] SLOT_INPUT = 2'h2;
   localparam logic [1:0] SLOT_OUTPUT = 2'h3;
   // Sub-register codes reached through the data slot
   localparam logic [7:0] SUB_DIRECTION = 8'h01;
   localparam logic [7:0] SUB_ALT_FUNCTION = 8'h02;
   localparam logic [7:0] SUB_OPEN_DRAIN = 8'h03;
   localparam logic [7:0] SUB_SELECT_RESET = 8'h00;
   localparam logic [7:0] SUB_DATA_RESET = 8'h00;
   localparam logic [7:0] OUTPUT_DRIVE_RESET = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {GPABC_W_IDLE, GPABC_W_RESP} gpabc_wstate_t;
   typedef enum logic [1:0] {GPABC_R_IDLE, GPABC_R_WAIT, GPABC_R_RESP} gpabc_rstate_t;
endpackage : gpabc_pkg

// file: logic/gpabc_subreg_mem.sv
// Small memory of per-port indirect sub-registers with a registered read port
`timescale 1ns/1ps
`default_nettype none
module gpabc_subreg_mem #(
   parameter int WORDS = 12,
   parameter int WIDTH = 8
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic wr_en,
   input wire logic [$clog2(WORDS)-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(WORDS)-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data,
   output logic [WORDS*WIDTH-1:0] all_words
);
   logic [WIDTH-1:0] mem_q [WORDS];
   logic [WIDTH-1:0] mem_d [WORDS];
   logic [WIDTH-1:0] rd_q;
   logic [WIDTH-1:0] rd_d;

   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         mem_d[i] = mem_q[i];
      end
      if (wr_en) begin
         mem_d[wr_addr] = wr_data;
      end
      rd_d = mem_q[rd_addr];
   end

   always_ff @(posedge CLK) begin
      for (int i = 0; i < WORDS; i++) begin
         mem_q[i] <= RESET ? '0 : mem_d[i];
      end
      rd_q <= RESET ? '0 : rd_d;
   end

   assign rd_data = rd_q;
   always_comb begin
      for (int i = 0; i < WORDS; i++) begin
         all_words[i*WIDTH +: WIDTH] = mem_q[i];
      end
   end
endmodule : gpabc_subreg_mem
`default_nettype wire

// file: logic/gpabc_pin_drive.sv
// Pin driver of one port: drive value, enables and input sampling
`timescale 1ns/1ps
`default_nettype none
module gpabc_pin_drive #(
   parameter int WIDTH = 8
) (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [WIDTH-1:0] drive_bits,
   input wire logic [WIDTH-1:0] output_dir,
   input wire logic [WIDTH-1:0] open_drain,
   input wire logic [WIDTH-1:0] pin_level,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe_n,
   output logic [WIDTH-1:0] sample
);
   logic [WIDTH-1:0] out_q, out_d, oe_n_q, oe_n_d, smp_q, smp_d;

   always_comb begin
      out_d = drive_bits;
      // Open-drain pins release the line instead of driving high
      oe_n_d = ~output_dir | (open_drain & drive_bits);
      smp_d = pin_level;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         out_q <= '0;
         oe_n_q <= '1;
         smp_q <= '0;
      end else begin
         out_q <= out_d;
         oe_n_q <= oe_n_d;
         smp_q <= smp_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe_n = oe_n_q;
   assign sample = smp_q;
endmodule : gpabc_pin_drive
`default_nettype wire

// file: logic/gpabc_regs.sv
// Top of the three-port GPIO register block with an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gpabc_regs (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [gpabc_pkg::ADDR_WIDTH-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [gpabc_pkg::ADDR_WIDTH-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [7:0] PORT_A_IN,
   input wire logic [7:0] PORT_B_IN,
   input wire logic [7:0] PORT_C_IN,
   output logic [7:0] PORT_A_OUT,
   output logic [7:0] PORT_B_OUT,
   output logic [7:0] PORT_C_OUT,
   output logic [7:0] PORT_A_OE_N,
   output logic [7:0] PORT_B_OE_N,
   output logic [7:0] PORT_C_OE_N
);
   localparam int NP = gpabc_pkg::PORT_COUNT;
   localparam int W = gpabc_pkg::PORT_WIDTH;
   localparam int NSUB = gpabc_pkg::SUBREG_COUNT;
   localparam int MWORDS = NP * NSUB;
   localparam int MAW = $clog2(MWORDS);

   // ****************************************************************
   // Address decode
   // ****************************************************************
   // Returns 1 when a byte address hits the map; yields port and slot
   function automatic logic decode(input logic [gpabc_pkg::ADDR_WIDTH-1:0] a,
                                   output logic [1:0] port, output logic [1:0] slot);
      logic [11:0] idx;
      logic [11:0] rel;
      idx = a[13:2];
      rel = idx - gpabc_pkg::FIRST_IDX;
      port = rel[3:2];
      slot = rel[1:0];
      decode = (a[1:0] == 2'h0) && (idx >= gpabc_pkg::FIRST_IDX)
               && (idx <= gpabc_pkg::LAST_IDX);
   endfunction : decode

   // Memory word of a sub-register; codes 1..3 are held, others read zero
   function automatic logic [MAW-1:0] sub_word(input logic [1:0] port, input logic [7:0] sel);
      sub_word = MAW'(port * NSUB + int'(sel[1:0]));
   endfunction : sub_word

   function automatic logic sub_valid(input logic [7:0] sel);
      sub_valid = (sel >= gpabc_pkg::SUB_DIRECTION) && (sel <= gpabc_pkg::SUB_OPEN_DRAIN);
   endfunction : sub_valid

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [W-1:0] sel_q [NP];
   logic [W-1:0] sel_d [NP];
   logic [W-1:0] drv_q [NP];
   logic [W-1:0] drv_d [NP];
   logic [W-1:0] smp [NP];
   logic [W-1:0] pin_in [NP];
   logic [W-1:0] pin_o [NP];
   logic [W-1:0] pin_oe [NP];
   logic [MWORDS*W-1:0] sub_all;
   logic mem_we;
   logic [MAW-1:0] mem_waddr;
   logic [W-1:0] mem_wdata;
   logic [MAW-1:0] mem_raddr;
   logic [W-1:0] mem_rdata;

   // ****************************************************************
   // Write channel
   // ****************************************************************
   gpabc_pkg::gpabc_wstate_t ws_q, ws_d;
   logic aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [gpabc_pkg::ADDR_WIDTH-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [1:0] wport, wslot;
   logic whit;

   always_comb begin
      ws_d = ws_q;
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      mem_we = 1'b0;
      mem_waddr = '0;
      mem_wdata = wdata_q[W-1:0];
      for (int p = 0; p < NP; p++) begin
         sel_d[p] = sel_q[p];
         drv_d[p] = drv_q[p];
      end
      whit = decode(awaddr_q, wport, wslot);
      unique case (ws_q)
         gpabc_pkg::GPABC_W_IDLE: begin
            if (S_AXI_AWVALID && awready_q) begin
               aw_have_d = 1'b1;
               awaddr_d = S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && wready_q) begin
               w_have_d = 1'b1;
               wdata_d = S_AXI_WDATA;
               wstrb0_d = S_AXI_WSTRB[0];
            end
            if (aw_have_q && w_have_q) begin
               // Data sits in byte lane 0; other lanes are ignored
               if (whit && wstrb0_q) begin
                  unique case (wslot)
                     gpabc_pkg::SLOT_SELECT: sel_d[wport] = wdata_q[W-1:0];
                     gpabc_pkg::SLOT_DATA: begin
                        mem_we = sub_valid(sel_q[wport]);
                        mem_waddr = sub_word(wport, sel_q[wport]);
                     end
                     gpabc_pkg::SLOT_INPUT: ;
                     gpabc_pkg::SLOT_OUTPUT: drv_d[wport] = wdata_q[W-1:0];
                  endcase
               end
               bresp_d = whit ? gpabc_pkg::RESP_OKAY : gpabc_pkg::RESP_SLVERR;
               bvalid_d = 1'b1;
               aw_have_d = 1'b0;
               w_have_d = 1'b0;
               ws_d = gpabc_pkg::GPABC_W_RESP;
            end
         end
         gpabc_pkg::GPABC_W_RESP: begin
            if (S_AXI_BREADY) begin
               bvalid_d = 1'b0;
               ws_d = gpabc_pkg::GPABC_W_IDLE;
            end
         end
         default: ws_d = gpabc_pkg::GPABC_W_IDLE;
      endcase
      awready_d = (ws_d == gpabc_pkg::GPABC_W_IDLE) && !aw_have_d;
      wready_d = (ws_d == gpabc_pkg::GPABC_W_IDLE) && !w_have_d;
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         ws_q <= gpabc_pkg::GPABC_W_IDLE;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= gpabc_pkg::RESP_OKAY;
         for (int p = 0; p < NP; p++) begin
            sel_q[p] <= gpabc_pkg::SUB_SELECT_RESET;
            drv_q[p] <= gpabc_pkg::OUTPUT_DRIVE_RESET;
         end
      end else begin
         ws_q <= ws_d;
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         for (int p = 0; p < NP; p++) begin
            sel_q[p] <= sel_d[p];
            drv_q[p] <= drv_d[p];
         end
      end
   end

   // ****************************************************************
   // Read channel
   // ****************************************************************
   // One wait cycle lets the sub-register memory present registered data
   gpabc_pkg::gpabc_rstate_t rs_q, rs_d;
   logic [gpabc_pkg::ADDR_WIDTH-1:0] araddr_q, araddr_d;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic [1:0] rport, rslot;
   logic rhit;
   logic [1:0] nport, nslot;
   logic nhit;
   logic [W-1:0] rbyte;

   always_comb begin
      rs_d = rs_q;
      araddr_d = araddr_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      rhit = decode(araddr_q, rport, rslot);
      unique case (rslot)
         gpabc_pkg::SLOT_SELECT: rbyte = sel_q[rport];
         gpabc_pkg::SLOT_DATA: rbyte = sub_valid(sel_q[rport]) ? mem_rdata : '0;
         gpabc_pkg::SLOT_INPUT: rbyte = smp[rport];
         gpabc_pkg::SLOT_OUTPUT: rbyte = drv_q[rport];
      endcase
      unique case (rs_q)
         gpabc_pkg::GPABC_R_IDLE: begin
            if (S_AXI_ARVALID && arready_q) begin
               araddr_d = S_AXI_ARADDR;
               rs_d = gpabc_pkg::GPABC_R_WAIT;
            end
         end
         gpabc_pkg::GPABC_R_WAIT: begin
            rdata_d = rhit ? {24'h000000, rbyte} : 32'h00000000;
            rresp_d = rhit ? gpabc_pkg::RESP_OKAY : gpabc_pkg::RESP_SLVERR;
            rvalid_d = 1'b1;
            rs_d = gpabc_pkg::GPABC_R_RESP;
         end
         gpabc_pkg::GPABC_R_RESP: begin
            if (S_AXI_RREADY) begin
               rvalid_d = 1'b0;
               rs_d = gpabc_pkg::GPABC_R_IDLE;
            end
         end
         default: rs_d = gpabc_pkg::GPABC_R_IDLE;
      endcase
      // Memory follows the incoming address, so its word stands by the wait cycle
      nhit = decode(araddr_d, nport, nslot);
      mem_raddr = nhit ? sub_word(nport, sel_q[nport]) : '0;
      arready_d = (rs_d == gpabc_pkg::GPABC_R_IDLE);
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         rs_q <= gpabc_pkg::GPABC_R_IDLE;
         araddr_q <= '0;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= gpabc_pkg::RESP_OKAY;
      end else begin
         rs_q <= rs_d;
         araddr_q <= araddr_d;
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ****************************************************************
   // Sub-registers and pins
   // ****************************************************************
   gpabc_subreg_mem #(.WORDS(MWORDS), .WIDTH(W)) u_mem (
      .CLK(CLK),
      .RESET(RESET),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(mem_raddr),
      .rd_data(mem_rdata),
      .all_words(sub_all)
   );

   assign pin_in[0] = PORT_A_IN;
   assign pin_in[1] = PORT_B_IN;
   assign pin_in[2] = PORT_C_IN;

   for (genvar p = 0; p < NP; p++) begin : g_port
      gpabc_pin_drive #(.WIDTH(W)) u_pin (
         .CLK(CLK),
         .RESET(RESET),
         .drive_bits(drv_q[p]),
         .output_dir(sub_all[(p*NSUB + int'(gpabc_pkg::SUB_DIRECTION[1:0]))*W +: W]),
         .open_drain(sub_all[(p*NSUB + int'(gpabc_pkg::SUB_OPEN_DRAIN[1:0]))*W +: W]),
         .pin_level(pin_in[p]),
         .pin_out(pin_o[p]),
         .pin_oe_n(pin_oe[p]),
         .sample(smp[p])
      );
   end

   assign PORT_A_OUT = pin_o[0];
   assign PORT_B_OUT = pin_o[1];
   assign PORT_C_OUT = pin_o[2];
   assign PORT_A_OE_N = pin_oe[0];
   assign PORT_B_OE_N = pin_oe[1];
   assign PORT_C_OE_N = pin_oe[2];
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
endmodule : gpabc_regs
`default_nettype wire

// file: sim/gpabc_regs_props.sv
// Assertion checker of the GPIO register block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module gpabc_regs_props (
   input wire logic CLK,
   input wire logic RESET,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic [1:0] S_AXI_BRESP,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic [1:0] S_AXI_RRESP,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [7:0] PORT_A_OUT,
   input wire logic [7:0] PORT_B_OUT,
   input wire logic [7:0] PORT_C_OUT,
   input wire logic [7:0] PORT_A_OE_N,
   input wire logic [7:0] PORT_B_OE_N,
   input wire logic [7:0] PORT_C_OE_N
);
   // ****************************************
   // Handshake, read data and reset state
   // ****************************************
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   sequence s_wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
   sequence s_wr_ans; !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID ##1 S_AXI_BVALID; endsequence
   sequence s_rd_ans; !S_AXI_ARREADY && !S_AXI_RVALID ##1 S_AXI_RVALID; endsequence
   property p_wr_resp; s_wr_take |=> s_wr_ans; endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write answer late or early");
   property p_rd_resp; S_AXI_ARVALID && S_AXI_ARREADY |=> s_rd_ans; endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read answer late or early");
   property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_upper; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits not zero");
   property p_err_data; S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0; endproperty
   a_err_data: assert property (p_err_data) else $error("refused read carries data");
   property p_pin_rst;
      $fell(RESET) |-> {PORT_A_OUT, PORT_B_OUT, PORT_C_OUT} == 24'h0
         && {PORT_A_OE_N, PORT_B_OE_N, PORT_C_OE_N} == 24'hffffff;
   endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("pins not released at reset");
   property p_rdy; $fell(RESET) |-> !S_AXI_ARREADY ##1 S_AXI_AWREADY && S_AXI_ARREADY; endproperty
   a_rdy: assert property (p_rdy) else $error("readies wrong after reset");
endmodule : gpabc_regs_props
bind gpabc_regs gpabc_regs_props u_props (.*);
`default_nettype wire

// file: sim/gpabc_pin_model.sv
// Board side of one port: released pins follow the board level
`timescale 1ns/1ps
`default_nettype none
module gpabc_pin_model (
   input wire logic [7:0] drive,
   input wire logic [7:0] drive_off_n,
   input wire logic [7:0] board_level,
   output logic [7:0] level
);
   // A driven pin shows the device value; a released one is held by the board
   assign level = (~drive_off_n & drive) | (drive_off_n & board_level);
endmodule : gpabc_pin_model
`default_nettype wire

// file: sim/tb_gpabc_regs.sv
// Self-checking testbench of the three-port GPIO register block
`timescale 1ns/1ps
`default_nettype none
module tb_gpabc_regs;
   // ****************************************
   // Signals, clock, design and board
   // ****************************************
   localparam logic [1:0] OK = gpabc_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = gpabc_pkg::RESP_SLVERR;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [13:0] awaddr = 14'h0, araddr = 14'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [7:0] port_drive_bits [3];
   logic [7:0] poe_n [3];
   logic [7:0] pin [3];
   logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
   int err_total = 0, checks = 0, cycles = 0;
   always #5 clk = ~clk;
   gpabc_regs u_dut (
      .CLK(clk), .RESET(reset),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .PORT_A_IN(pin[0]), .PORT_B_IN(pin[1]), .PORT_C_IN(pin[2]),
      .PORT_A_OUT(port_drive_bits[0]), .PORT_B_OUT(port_drive_bits[1]), .PORT_C_OUT(port_drive_bits[2]),
      .PORT_A_OE_N(poe_n[0]), .PORT_B_OE_N(poe_n[1]), .PORT_C_OE_N(poe_n[2])
   );
   for (genvar g = 0; g < 3; g++) begin : g_pins
      gpabc_pin_model u_pins (.drive(port_drive_bits[g]), .drive_off_n(poe_n[g]),
         .board_level(ext[g]), .level(pin[g]));
   end
   // ****************************************
   // Compare, bus and closing tasks
   // ****************************************
   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: data %h expected %h", $time, got, exp);
      end
   endtask : cmp_data
   task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
      end
   endtask : cmp_resp
   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: pins %h expected %h", $time, got, exp);
      end
   endtask : cmp_pin
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   // Address and data leave together; each is dropped on its own handshake edge
   task automatic axw(input logic [13:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
      bit ad, wd;
      ad = 1'h0;
      wd = 1'h0;
      awaddr <= a;
      wdata <= {24'h0, d};
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(ad && wd)) begin
         @(posedge clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         ad = ad || awready === 1'h1;
         wd = wd || wready === 1'h1;
      end
      do @(posedge clk); while (bvalid !== 1'h1);
      // Late ready makes the response stand for a cycle
      bready <= 1'h1;
      @(posedge clk);
      cmp_resp(bresp, er);
      bready <= 1'h0;
      @(posedge clk);
   endtask : axw
   task automatic rd(input logic [13:0] a, input logic [7:0] ed, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      rready <= 1'h1;
      @(posedge clk);
      cmp_data(rdata, {24'h0, ed});
      cmp_resp(rresp, er);
      rready <= 1'h0;
      @(posedge clk);
   endtask : rd
   function automatic logic [13:0] ra(input int p, input int s);
      return {gpabc_pkg::FIRST_IDX + 12'(p * 4 + s), 2'h0};
   endfunction : ra
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         results();
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      logic [7:0] dir, od, af, ov, oe, v;
      v = 8'($urandom(14773));
      repeat (16) @(posedge clk);
      reset <= 1'h0;
      @(posedge clk);
      for (int p = 0; p < 3; p++) begin
         rd(ra(p, 0), gpabc_pkg::SUB_SELECT_RESET, OK);
         rd(ra(p, 1), gpabc_pkg::SUB_DATA_RESET, OK);
         rd(ra(p, 3), gpabc_pkg::OUTPUT_DRIVE_RESET, OK);
         cmp_pin(poe_n[p], 8'hff);
      end
      $display("test reset_values done");
      for (int p = 0; p < 3; p++) begin
         v = 8'($urandom);
         dir = (p == 2) ? 8'($urandom) : 8'hff;
         od = (p == 0) ? 8'h00 : ((p == 1) ? 8'hff : 8'($urandom));
         af = 8'($urandom);
         ov = 8'($urandom);
         axw(ra(p, 0), v, 4'hf, OK);
         rd(ra(p, 0), v, OK);
         axw(ra(p, 0), gpabc_pkg::SUB_DIRECTION, 4'hf, OK);
         axw(ra(p, 1), dir, 4'hf, OK);
         axw(ra(p, 0), gpabc_pkg::SUB_OPEN_DRAIN, 4'hf, OK);
         axw(ra(p, 1), od, 4'hf, OK);
         axw(ra(p, 0), gpabc_pkg::SUB_ALT_FUNCTION, 4'hf, OK);
         axw(ra(p, 1), af, 4'hf, OK);
         rd(ra(p, 1), af, OK);
         axw(ra(p, 0), 8'h05, 4'hf, OK);
         axw(ra(p, 1), 8'h5a, 4'hf, OK);
         rd(ra(p, 1), 8'h00, OK);
         axw(ra(p, 0), gpabc_pkg::SUB_DIRECTION, 4'hf, OK);
         rd(ra(p, 1), dir, OK);
         axw(ra(p, 3), ov, 4'hf, OK);
         axw(ra(p, 3), ~ov, 4'he, OK);
         rd(ra(p, 3), ov, OK);
         repeat (3) @(posedge clk);
         oe = ~dir | (od & ov);
         cmp_pin(port_drive_bits[p], ov);
         cmp_pin(poe_n[p], oe);
         ext[p] <= 8'($urandom);
         repeat (3) @(posedge clk);
         v = (~oe & ov) | (oe & ext[p]);
         rd(ra(p, 2), v, OK);
         axw(ra(p, 2), ~v, 4'hf, OK);
         rd(ra(p, 2), v, OK);
      end
      $display("test port_registers_and_pins done");
      rd({12'hfdc, 2'h0}, 8'h00, ERR);
      axw({12'hfcf, 2'h0}, 8'h12, 4'hf, ERR);
      axw({gpabc_pkg::PORT_C_OUTPUT_DRIVE_IDX, 2'h2}, ~ov, 4'hf, ERR);
      rd(ra(2, 3), ov, OK);
      // Port A data slot right after a port C read: select still points at direction
      rd(ra(0, 1), 8'hff, OK);
      $display("test refused_accesses done");
      results();
   end
endmodule : tb_gpabc_regs
`default_nettype wire
